// ===== rtl/cbbx_defines.svh
`ifndef CBBX_DEFINES_SVH
`define CBBX_DEFINES_SVH
// Functional notes
// - Compare-skip-equal skips next instruction when registers equal; 1/2/3 clocks.
// - Compares subtract without storing; update Z,N,V,C,H; one clock.
// - Register bit skips test a working register bit; skip on match; no flags.
// - I/O bit skips test an I/O register bit; skip on match; no flags.
// - Generic flag branch tests selected status bit; taken target PC+k+1; 1/2 clocks.
// - Same-or-higher taken on carry 0, lower on carry 1.
// - Signed branches use N xor V: less on 1, greater-equal on 0.
// - Half-carry branches taken on H set or clear variant.
// - Transfer-flag branches taken on T set or clear variant.
// - Overflow branches taken on V set or clear, flags unchanged.
// - Interrupt-state branches taken on I set or clear variant.
// - I/O bit set writes one to addressed bit, others kept, two clocks.
// - I/O bit clear writes zero to addressed bit, others kept, two clocks.
// - Rotate left: old carry into bit 0, bit 7 into carry; Z,C,N,V.
// - Rotate right: old carry into bit 7, bit 0 into carry; Z,C,N,V.
// - Arithmetic shift right keeps bit 7; updates Z,C,N,V.
// - Bit store copies selected register bit into T only.
`define CBBX_FLAG_C 0
`define CBBX_FLAG_Z 1
`define CBBX_FLAG_N 2
`define CBBX_FLAG_V 3
`define CBBX_FLAG_S 4
`define CBBX_FLAG_H 5
`define CBBX_FLAG_T 6
`define CBBX_FLAG_I 7
`define CBBX_STATUS_RESET 8'h00
`define CBBX_IO_CYCLES 2
`define CBBX_SKIP_ONE_WORD 2
`define CBBX_SKIP_TWO_WORD 3
`endif

// ===== rtl/cbbx_pkg.sv
package cbbx_pkg;
	typedef enum logic [4:0] {
		CBBX_NOP, CBBX_CPSEQ, CBBX_CMP, CBBX_CMPC, CBBX_CMPI,
		CBBX_SKRC, CBBX_SKRS, CBBX_SKIC, CBBX_SKIS,
		CBBX_BFS, CBBX_BFC, CBBX_BSH, CBBX_BLO, CBBX_BLT, CBBX_BGE,
		CBBX_BHS, CBBX_BHC, CBBX_BTS, CBBX_BTC, CBBX_BVS, CBBX_BVC,
		CBBX_BIE, CBBX_BID, CBBX_IOSET, CBBX_IOCLR,
		CBBX_RLC, CBBX_RRC, CBBX_SRA, CBBX_SLL, CBBX_SRL, CBBX_SWAP, CBBX_TSTORE
	} cbbx_op_t;
	typedef enum {CBBX_IDLE, CBBX_WAIT, CBBX_IOWR} cbbx_state_t;
endpackage

// ===== rtl/cbbx_flags.sv
`timescale 1ns/10ps
`include "cbbx_defines.svh"
module cbbx_flags #(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] a,
	input wire logic [WIDTH-1:0] b,
	input wire logic cin,
	output logic [WIDTH-1:0] diff,
	output logic z,
	output logic n,
	output logic v,
	output logic c,
	output logic h
);
	initial begin
		if (WIDTH != 8) $error("cbbx_flags serves 8-bit data only");
	end
	logic [WIDTH:0] full;
	logic [4:0] low;
	// Subtract only; caller decides whether anything is stored
	always_comb begin
		full = {1'b0, a} - {1'b0, b} - {{WIDTH{1'b0}}, cin};
		low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
		diff = full[WIDTH-1:0];
		c = full[WIDTH];
		h = low[4];
		n = diff[WIDTH-1];
		v = (a[WIDTH-1] & ~b[WIDTH-1] & ~diff[WIDTH-1])
			| (~a[WIDTH-1] & b[WIDTH-1] & diff[WIDTH-1]);
		z = (diff == {WIDTH{1'b0}});
	end
endmodule

// ===== rtl/cbbx_exec.sv
`timescale 1ns/10ps
`include "cbbx_defines.svh"
module cbbx_exec #(
	parameter int PC_W = 16
) (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic OP_VALID,
	input wire cbbx_pkg::cbbx_op_t OP_CODE,
	input wire logic [7:0] RD_DATA,
	input wire logic [7:0] RR_DATA,
	input wire logic [7:0] IMM_DATA,
	input wire logic [2:0] BIT_SEL,
	input wire logic [6:0] BR_OFFSET,
	input wire logic NEXT_IS_TWO_WORD,
	input wire logic [7:0] IO_RDATA,
	input wire logic [7:0] STATUS_IN,
	input wire logic STATUS_LOAD,
	input wire logic [PC_W-1:0] PC_IN,
	output logic BUSY,
	output logic DONE,
	output logic [PC_W-1:0] PC_OUT,
	output logic PC_LOAD,
	output logic [7:0] RESULT,
	output logic RESULT_WE,
	output logic [7:0] IO_WDATA,
	output logic IO_WE,
	output logic [7:0] STATUS_OUT
);
	initial begin
		if (PC_W < 8 || PC_W > 32) $error("PC_W out of range");
	end
	cbbx_pkg::cbbx_state_t state_reg;
	logic [1:0] wait_reg;
	logic [7:0] stat_reg;
	logic [7:0] stat_next;
	logic [7:0] cmp_diff;
	logic cz;
	logic cn;
	logic cv;
	logic cc;
	logic ch;
	logic cin;
	logic [7:0] cmp_b;
	logic is_br;
	logic take_br;
	logic is_skip;
	logic skip_hit;
	logic is_cmp;
	logic is_io;
	logic redirect;
	logic [7:0] sh_val;
	logic sh_c;
	logic sh_upd;
	logic [PC_W-1:0] off_ext;
	logic [PC_W-1:0] rel_tgt;
	logic [PC_W-1:0] skip_tgt;
	logic accept;
	logic done_now;
	logic done_wait;
	logic done_io;
	logic flag_c;
	logic flag_z;
	logic flag_n;
	logic flag_v;
	logic flag_h;
	logic flag_t;
	logic flag_i;

	assign accept = OP_VALID && (state_reg == cbbx_pkg::CBBX_IDLE);
	assign BUSY = (state_reg != cbbx_pkg::CBBX_IDLE);
	assign STATUS_OUT = stat_reg;

	// Named flag taps keep the decode readable
	assign flag_c = stat_reg[`CBBX_FLAG_C];
	assign flag_z = stat_reg[`CBBX_FLAG_Z];
	assign flag_n = stat_reg[`CBBX_FLAG_N];
	assign flag_v = stat_reg[`CBBX_FLAG_V];
	assign flag_h = stat_reg[`CBBX_FLAG_H];
	assign flag_t = stat_reg[`CBBX_FLAG_T];
	assign flag_i = stat_reg[`CBBX_FLAG_I];

	// Compare with carry chains the previous borrow
	assign cin = (OP_CODE == cbbx_pkg::CBBX_CMPC) ? flag_c : 1'b0;
	assign cmp_b = (OP_CODE == cbbx_pkg::CBBX_CMPI) ? IMM_DATA : RR_DATA;
	assign is_cmp = (OP_CODE == cbbx_pkg::CBBX_CMP) || (OP_CODE == cbbx_pkg::CBBX_CMPC)
		|| (OP_CODE == cbbx_pkg::CBBX_CMPI);
	assign is_io = (OP_CODE == cbbx_pkg::CBBX_IOSET)
		|| (OP_CODE == cbbx_pkg::CBBX_IOCLR);

	cbbx_flags #(.WIDTH(8)) u_cmp (
		.a(RD_DATA),
		.b(cmp_b),
		.cin(cin),
		.diff(cmp_diff),
		.z(cz),
		.n(cn),
		.v(cv),
		.c(cc),
		.h(ch)
	);

	// Branch condition decode
	always_comb begin
		is_br = 1'b1;
		take_br = 1'b0;
		unique case (OP_CODE)
			cbbx_pkg::CBBX_BFS: begin
				take_br = stat_reg[BIT_SEL];
			end
			cbbx_pkg::CBBX_BFC: begin
				take_br = ~stat_reg[BIT_SEL];
			end
			cbbx_pkg::CBBX_BSH: begin
				take_br = ~flag_c;
			end
			cbbx_pkg::CBBX_BLO: begin
				take_br = flag_c;
			end
			cbbx_pkg::CBBX_BLT: begin
				take_br = flag_n ^ flag_v;
			end
			cbbx_pkg::CBBX_BGE: begin
				take_br = ~(flag_n ^ flag_v);
			end
			cbbx_pkg::CBBX_BHS: begin
				take_br = flag_h;
			end
			cbbx_pkg::CBBX_BHC: begin
				take_br = ~flag_h;
			end
			cbbx_pkg::CBBX_BTS: begin
				take_br = flag_t;
			end
			cbbx_pkg::CBBX_BTC: begin
				take_br = ~flag_t;
			end
			cbbx_pkg::CBBX_BVS: begin
				take_br = flag_v;
			end
			cbbx_pkg::CBBX_BVC: begin
				take_br = ~flag_v;
			end
			cbbx_pkg::CBBX_BIE: begin
				take_br = flag_i;
			end
			cbbx_pkg::CBBX_BID: begin
				take_br = ~flag_i;
			end
			default: begin
				is_br = 1'b0;
			end
		endcase
	end

	// Skip condition decode
	always_comb begin
		is_skip = 1'b1;
		skip_hit = 1'b0;
		unique case (OP_CODE)
			cbbx_pkg::CBBX_CPSEQ: begin
				skip_hit = (RD_DATA == RR_DATA);
			end
			cbbx_pkg::CBBX_SKRC: begin
				skip_hit = ~RR_DATA[BIT_SEL];
			end
			cbbx_pkg::CBBX_SKRS: begin
				skip_hit = RR_DATA[BIT_SEL];
			end
			cbbx_pkg::CBBX_SKIC: begin
				skip_hit = ~IO_RDATA[BIT_SEL];
			end
			cbbx_pkg::CBBX_SKIS: begin
				skip_hit = IO_RDATA[BIT_SEL];
			end
			default: begin
				is_skip = 1'b0;
			end
		endcase
	end

	// Offset is signed; target is PC plus offset plus one
	assign off_ext = {{(PC_W-7){BR_OFFSET[6]}}, BR_OFFSET};
	assign rel_tgt = PC_IN + off_ext + PC_W'(1);
	// Caller must flag a two-word follower, the block cannot see it
	assign skip_tgt = PC_IN + (NEXT_IS_TWO_WORD ? PC_W'(`CBBX_SKIP_TWO_WORD)
		: PC_W'(`CBBX_SKIP_ONE_WORD));
	assign redirect = (is_br && take_br) || (is_skip && skip_hit);

	// Shift and rotate datapath
	always_comb begin
		sh_val = RD_DATA;
		sh_c = flag_c;
		sh_upd = 1'b1;
		unique case (OP_CODE)
			cbbx_pkg::CBBX_RLC: begin
				sh_val = {RD_DATA[6:0], flag_c};
				sh_c = RD_DATA[7];
			end
			cbbx_pkg::CBBX_RRC: begin
				sh_val = {flag_c, RD_DATA[7:1]};
				sh_c = RD_DATA[0];
			end
			cbbx_pkg::CBBX_SRA: begin
				sh_val = {RD_DATA[7], RD_DATA[7:1]};
				sh_c = RD_DATA[0];
			end
			cbbx_pkg::CBBX_SLL: begin
				sh_val = {RD_DATA[6:0], 1'b0};
				sh_c = RD_DATA[7];
			end
			cbbx_pkg::CBBX_SRL: begin
				sh_val = {1'b0, RD_DATA[7:1]};
				sh_c = RD_DATA[0];
			end
			default: sh_upd = 1'b0;
		endcase
	end

	// Status next value; S is left alone, only the listed flags move
	always_comb begin
		stat_next = stat_reg;
		if (is_cmp) begin
			stat_next[`CBBX_FLAG_C] = cc;
			stat_next[`CBBX_FLAG_N] = cn;
			stat_next[`CBBX_FLAG_V] = cv;
			stat_next[`CBBX_FLAG_H] = ch;
			// Carry-chained compare only keeps Z clear across the chain
			if (OP_CODE == cbbx_pkg::CBBX_CMPC) begin
				stat_next[`CBBX_FLAG_Z] = cz & flag_z;
			end else begin
				stat_next[`CBBX_FLAG_Z] = cz;
			end
		end else if (OP_CODE == cbbx_pkg::CBBX_TSTORE) begin
			stat_next[`CBBX_FLAG_T] = RR_DATA[BIT_SEL];
		end else if (sh_upd) begin
			stat_next[`CBBX_FLAG_C] = sh_c;
			stat_next[`CBBX_FLAG_Z] = (sh_val == 8'h00);
			stat_next[`CBBX_FLAG_N] = sh_val[7];
			stat_next[`CBBX_FLAG_V] = sh_val[7] ^ sh_c;
		end
	end

	// Status register; an external load has priority only when no op is accepted
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			stat_reg <= `CBBX_STATUS_RESET;
		end else if (accept) begin
			stat_reg <= stat_next;
		end else if (STATUS_LOAD) begin
			stat_reg <= STATUS_IN;
		end
	end

	// Sequencer: extra clocks for taken branches, skips and I/O writes
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			state_reg <= cbbx_pkg::CBBX_IDLE;
			wait_reg <= 2'h0;
		end else begin
			unique case (state_reg)
				cbbx_pkg::CBBX_IDLE: begin
					if (accept && is_br && take_br) begin
						state_reg <= cbbx_pkg::CBBX_WAIT;
						wait_reg <= 2'h0;
					end else if (accept && is_skip && skip_hit) begin
						state_reg <= cbbx_pkg::CBBX_WAIT;
						wait_reg <= NEXT_IS_TWO_WORD ? 2'h1 : 2'h0;
					end else if (accept && is_io) begin
						state_reg <= cbbx_pkg::CBBX_IOWR;
					end
				end
				cbbx_pkg::CBBX_WAIT: begin
					if (wait_reg == 2'h0) begin
						state_reg <= cbbx_pkg::CBBX_IDLE;
					end else begin
						wait_reg <= wait_reg - 2'h1;
					end
				end
				cbbx_pkg::CBBX_IOWR: begin
					state_reg <= cbbx_pkg::CBBX_IDLE;
				end
			endcase
		end
	end

	// Result value; held until the next shift or swap
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			RESULT <= 8'h00;
		end else if (accept && sh_upd) begin
			RESULT <= sh_val;
		end else if (accept && OP_CODE == cbbx_pkg::CBBX_SWAP) begin
			RESULT <= {RD_DATA[3:0], RD_DATA[7:4]};
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			RESULT_WE <= 1'b0;
		end else begin
			RESULT_WE <= accept && (sh_upd || OP_CODE == cbbx_pkg::CBBX_SWAP);
		end
	end

	// Read-modify-write of the port value seen at acceptance
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			IO_WDATA <= 8'h00;
		end else if (accept && OP_CODE == cbbx_pkg::CBBX_IOSET) begin
			IO_WDATA <= IO_RDATA | (8'h01 << BIT_SEL);
		end else if (accept && OP_CODE == cbbx_pkg::CBBX_IOCLR) begin
			IO_WDATA <= IO_RDATA & ~(8'h01 << BIT_SEL);
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			PC_LOAD <= 1'b0;
		end else begin
			PC_LOAD <= accept && redirect;
		end
	end

	// Program counter redirect registered at acceptance
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			PC_OUT <= '0;
		end else if (accept && redirect) begin
			PC_OUT <= is_br ? rel_tgt : skip_tgt;
		end
	end

	assign IO_WE = (state_reg == cbbx_pkg::CBBX_IOWR);
	// Completion: same cycle for one-clock ops, else when the sequencer drains
	assign done_io = (state_reg == cbbx_pkg::CBBX_IOWR);
	assign done_wait = (state_reg == cbbx_pkg::CBBX_WAIT) && (wait_reg == 2'h0);
	assign done_now = accept && !redirect && !is_io;
	assign DONE = done_io || done_wait || done_now;
endmodule

// ===== tb/cbbx_exec_sva.sv
`timescale 1ns/10ps
module cbbx_exec_sva #(
	parameter int PC_W = 16
) (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic OP_VALID,
	input wire cbbx_pkg::cbbx_op_t OP_CODE,
	input wire logic [7:0] RD_DATA,
	input wire logic [7:0] RR_DATA,
	input wire logic [2:0] BIT_SEL,
	input wire logic [6:0] BR_OFFSET,
	input wire logic NEXT_IS_TWO_WORD,
	input wire logic [7:0] IO_RDATA,
	input wire logic [PC_W-1:0] PC_IN,
	input wire logic BUSY,
	input wire logic [PC_W-1:0] PC_OUT,
	input wire logic PC_LOAD,
	input wire logic [7:0] RESULT,
	input wire logic RESULT_WE,
	input wire logic [7:0] IO_WDATA,
	input wire logic IO_WE,
	input wire logic [7:0] STATUS_OUT
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	wire logic acc = OP_VALID && !BUSY;
	// Sign extension of the 7-bit offset, target is PC plus offset plus one
	wire logic [PC_W-1:0] tgt = PC_IN + {{(PC_W-7){BR_OFFSET[6]}}, BR_OFFSET} + 1'h1;
	a_rotate_left: assert property (acc && OP_CODE == cbbx_pkg::CBBX_RLC |=> RESULT_WE &&
		RESULT == {$past(RD_DATA[6:0]), $past(STATUS_OUT[0])} && STATUS_OUT[0] == $past(RD_DATA[7]))
		else $error("rotate left result wrong");
	a_sra_keep_msb: assert property (acc && OP_CODE == cbbx_pkg::CBBX_SRA |=>
		RESULT == {$past(RD_DATA[7]), $past(RD_DATA[7:1])} && STATUS_OUT[0] == $past(RD_DATA[0]))
		else $error("arithmetic shift result wrong");
	a_swap_no_flags: assert property (acc && OP_CODE == cbbx_pkg::CBBX_SWAP |=>
		RESULT == {$past(RD_DATA[3:0]), $past(RD_DATA[7:4])} && $stable(STATUS_OUT))
		else $error("nibble swap wrong");
	a_cmp_no_store: assert property (acc && OP_CODE == cbbx_pkg::CBBX_CMP |=> !RESULT_WE &&
		STATUS_OUT[1] == ($past(RD_DATA) == $past(RR_DATA)) && STATUS_OUT[0] == ($past(RD_DATA) < $past(RR_DATA)))
		else $error("compare flags wrong");
	a_bit_to_t: assert property (acc && OP_CODE == cbbx_pkg::CBBX_TSTORE |=> STATUS_OUT ==
		{$past(STATUS_OUT[7]), $past(RR_DATA[BIT_SEL]), $past(STATUS_OUT[5:0])})
		else $error("bit store wrong");
	a_io_set_bit: assert property (acc && OP_CODE == cbbx_pkg::CBBX_IOSET |=> IO_WE &&
		IO_WDATA == ($past(IO_RDATA) | (8'h01 << $past(BIT_SEL))) && $stable(STATUS_OUT) ##1 !IO_WE)
		else $error("io set write wrong");
	a_io_clr_bit: assert property (acc && OP_CODE == cbbx_pkg::CBBX_IOCLR |=> IO_WE &&
		IO_WDATA == ($past(IO_RDATA) & ~(8'h01 << $past(BIT_SEL))) ##1 !IO_WE)
		else $error("io clear write wrong");
	a_skip_equal: assert property (acc && OP_CODE == cbbx_pkg::CBBX_CPSEQ && RD_DATA == RR_DATA &&
		!NEXT_IS_TWO_WORD |=> PC_LOAD && PC_OUT == PC_W'($past(PC_IN) + 2))
		else $error("skip target wrong");
	a_branch_lower: assert property (acc && OP_CODE == cbbx_pkg::CBBX_BLO && STATUS_OUT[0] |=>
		PC_LOAD && PC_OUT == $past(tgt)) else $error("lower branch wrong");
	a_signed_less: assert property (acc && OP_CODE == cbbx_pkg::CBBX_BLT &&
		!(STATUS_OUT[2] ^ STATUS_OUT[3]) |=> !PC_LOAD) else $error("signed branch taken wrongly");
endmodule
bind cbbx_exec cbbx_exec_sva #(.PC_W(PC_W)) u_sva (.*);

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
	logic CORE_CLK = 1'h0, SYS_RST = 1'h1, OP_VALID = 1'h0, NEXT_IS_TWO_WORD = 1'h0;
	logic STATUS_LOAD = 1'h0, BUSY, DONE, PC_LOAD, RESULT_WE, IO_WE;
	cbbx_pkg::cbbx_op_t OP_CODE = cbbx_pkg::CBBX_NOP;
	logic [7:0] RD_DATA = 8'h00, RR_DATA = 8'h00, IMM_DATA = 8'h07, IO_RDATA = 8'h00;
	logic [7:0] STATUS_IN = 8'h00, RESULT, IO_WDATA, STATUS_OUT, io_got;
	logic [2:0] BIT_SEL = 3'h0;
	logic [6:0] BR_OFFSET = 7'h7E;
	logic [15:0] PC_IN = 16'h0100, PC_OUT, pc_got;
	logic pc_seen = 1'h0;
	int err_count = 0, n_checks = 0;
	int done_n = 0, busy_n = 0, we_n = 0;
	cbbx_exec #(.PC_W(16)) uut (.*);
	initial forever #50 CORE_CLK = ~CORE_CLK;
	// Pulses are caught here so a late skip completion is not missed
	always @(posedge CORE_CLK) begin
		if (PC_LOAD === 1'h1) begin
			pc_seen = 1'h1;
			pc_got = PC_OUT;
		end
		if (IO_WE === 1'h1) io_got = IO_WDATA;
		if (DONE === 1'h1) done_n++;
		if (BUSY === 1'h1) busy_n++;
		if (RESULT_WE === 1'h1) we_n++;
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task setsr(input logic [7:0] v);
		@(posedge CORE_CLK);
		STATUS_LOAD <= 1'h1;
		STATUS_IN <= v;
		@(posedge CORE_CLK);
		STATUS_LOAD <= 1'h0;
	endtask
	// Three idle cycles cover the longest op, a skip over a two-word instruction
	task run(input cbbx_pkg::cbbx_op_t op, input logic [7:0] rd, rr, input logic [2:0] b,
		input logic two, input logic [7:0] io);
		pc_seen = 1'h0;
		done_n = 0;
		busy_n = 0;
		we_n = 0;
		@(posedge CORE_CLK);
		OP_VALID <= 1'h1;
		OP_CODE <= op;
		RD_DATA <= rd;
		RR_DATA <= rr;
		BIT_SEL <= b;
		NEXT_IS_TWO_WORD <= two;
		IO_RDATA <= io;
		@(posedge CORE_CLK);
		OP_VALID <= 1'h0;
		repeat (3) @(posedge CORE_CLK);
		#1;
	endtask
	task sk(input cbbx_pkg::cbbx_op_t op, input logic [7:0] rd, rr, input logic [2:0] b,
		input logic two, input logic [7:0] io, input logic [15:0] exp);
		run(op, rd, rr, b, two, io);
		chk(pc_seen ? pc_got : 16'h0000, exp);
		chk(16'(busy_n), exp == 16'h0000 ? 16'h0000 : (exp == 16'h0103 ? 16'h0002 : 16'h0001));
		chk(16'(done_n), 16'h0001);
	endtask
	task t_shift;
		cbbx_pkg::cbbx_op_t ops[6] = '{cbbx_pkg::CBBX_RLC, cbbx_pkg::CBBX_RRC, cbbx_pkg::CBBX_SRA,
			cbbx_pkg::CBBX_SLL, cbbx_pkg::CBBX_SRL, cbbx_pkg::CBBX_SWAP};
		logic [7:0] res[6] = '{8'h01, 8'hC0, 8'hC0, 8'h00, 8'h40, 8'h08};
		logic [7:0] st[6] = '{8'h09, 8'h0C, 8'h0C, 8'h0B, 8'h00, 8'h01};
		for (int i = 0; i < 6; i++) begin
			setsr(8'h01);
			run(ops[i], 8'h80, 8'h00, 3'h0, 1'h0, 8'h00);
			chk(16'(RESULT), 16'(res[i]));
			chk(16'(STATUS_OUT), 16'(st[i]));
			chk(16'(we_n), 16'h0001);
			chk(16'(busy_n), 16'h0000);
		end
	endtask
	task t_cmp;
		setsr(8'h00);
		run(cbbx_pkg::CBBX_CMP, 8'h05, 8'h07, 3'h0, 1'h0, 8'h00);
		chk(16'(STATUS_OUT), 16'h0025);
		chk(16'(we_n), 16'h0000);
		run(cbbx_pkg::CBBX_CMPI, 8'h07, 8'h00, 3'h0, 1'h0, 8'h00);
		chk(16'(STATUS_OUT), 16'h0002);
		run(cbbx_pkg::CBBX_CMPC, 8'h07, 8'h07, 3'h0, 1'h0, 8'h00);
		chk(16'(STATUS_OUT), 16'h0002);
		chk(16'(done_n), 16'h0001);
	endtask
	task t_skip;
		setsr(8'hA5);
		sk(cbbx_pkg::CBBX_CPSEQ, 8'h33, 8'h33, 3'h0, 1'h0, 8'h00, 16'h0102);
		sk(cbbx_pkg::CBBX_CPSEQ, 8'h33, 8'h33, 3'h0, 1'h1, 8'h00, 16'h0103);
		sk(cbbx_pkg::CBBX_CPSEQ, 8'h33, 8'h34, 3'h0, 1'h0, 8'h00, 16'h0000);
		sk(cbbx_pkg::CBBX_SKRC, 8'h00, 8'hFE, 3'h0, 1'h0, 8'h00, 16'h0102);
		sk(cbbx_pkg::CBBX_SKRS, 8'h00, 8'hFE, 3'h0, 1'h0, 8'h00, 16'h0000);
		sk(cbbx_pkg::CBBX_SKRS, 8'h00, 8'hFE, 3'h7, 1'h1, 8'h00, 16'h0103);
		sk(cbbx_pkg::CBBX_SKIC, 8'h00, 8'h00, 3'h0, 1'h0, 8'h01, 16'h0000);
		sk(cbbx_pkg::CBBX_SKIS, 8'h00, 8'h00, 3'h0, 1'h0, 8'h01, 16'h0102);
		sk(cbbx_pkg::CBBX_SKIC, 8'h00, 8'h00, 3'h3, 1'h1, 8'h01, 16'h0103);
		chk(16'(STATUS_OUT), 16'h00A5);
	endtask
	// Bit i of the mask: branch op i is taken with all flags clear
	task t_branch;
		cbbx_pkg::cbbx_op_t op;
		logic [13:0] mask = 14'h2AA6;
		for (int s = 0; s < 2; s++) begin
			setsr(s ? 8'hFB : 8'h00);
			op = cbbx_pkg::CBBX_BFS;
			for (int i = 0; i < 14; i++) begin
				run(op, 8'h00, 8'h00, 3'h3, 1'h0, 8'h00);
				chk(pc_seen ? pc_got : 16'h0000, (mask[i] ^ s[0]) ? 16'h00FF : 16'h0000);
				chk(16'(busy_n), (mask[i] ^ s[0]) ? 16'h0001 : 16'h0000);
				op = op.next();
			end
		end
	endtask
	task t_io_bst;
		setsr(8'h00);
		run(cbbx_pkg::CBBX_IOSET, 8'h00, 8'h00, 3'h7, 1'h0, 8'h5A);
		chk(16'(io_got), 16'h00DA);
		chk(16'(busy_n), 16'h0001);
		chk(16'(done_n), 16'h0001);
		run(cbbx_pkg::CBBX_IOCLR, 8'h00, 8'h00, 3'h1, 1'h0, 8'h5A);
		chk(16'(io_got), 16'h0058);
		run(cbbx_pkg::CBBX_TSTORE, 8'h00, 8'h40, 3'h6, 1'h0, 8'h00);
		chk(16'(STATUS_OUT), 16'h0040);
		setsr(8'hFF);
		run(cbbx_pkg::CBBX_TSTORE, 8'h00, 8'hBF, 3'h6, 1'h0, 8'h00);
		chk(16'(STATUS_OUT), 16'h00BF);
	endtask
	initial begin
		#1000000;
		err_count++;
		report_and_stop;
	end
	initial begin
		repeat (10) @(posedge CORE_CLK);
		SYS_RST <= 1'h0;
		t_shift;
		t_cmp;
		t_skip;
		t_branch;
		t_io_bst;
		report_and_stop;
	end
endmodule
